// [design/rcc_command_control.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Writing 1 to bit 31 resets core except registers, timing; bit self-clears.
// - Writing 1 to bit 30 resets only timing generator; bit self-clears.
// - Writing 1 to bit 29 resets the register block; bit then reads 0.
// - Command bits 31 to 25 clear themselves once their action is done.
// - Writing 0 to a command bit does nothing.
// - Writing 1 to bit 26 aborts the running RF test; bit self-clears.
// - Infinite transmit abort finishes current byte, then CRC, then stops.
// - Infinite receive abort finishes packet if address seen, else radio off.
// - Writing 1 to bit 25 aborts the advertising event; bit self-clears.
module rcc_command_control #(
    parameter int ADDR_W     = 32,
    parameter int HOLD_COUNT = rcc_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // AXI4-Lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // AXI4-Lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // Soft reset outputs
    output logic                   coreSoftReset,
    output logic                   timingGenSoftReset,
    output logic                   regBlockSoftReset,
    // Advertising abort handshake
    output logic                   advertisingAbortReq,
    input  wire logic              advertisingAbortDone,
    // RF test abort, packet controller side
    input  wire logic [1:0]        testFormat,
    input  wire logic              byteDone,
    input  wire logic              crcDone,
    input  wire logic              accessAddrSeen,
    input  wire logic              packetDone,
    output logic                   txStopAtByte,
    output logic                   crcFinish,
    output logic                   rxFinishPacket,
    output logic                   radioOff
);

    localparam int CW = $clog2(HOLD_COUNT + 1);

    // Both checks raise an elaboration error, so a bad parameter never reaches simulation.
    if (HOLD_COUNT < 1 || HOLD_COUNT > 255) begin : g_bad_hold
        $error("HOLD_COUNT must lie between 1 and 255");
    end
    if (ADDR_W < 27 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 27 and 32");
    end

    typedef struct packed {
        logic                   awHeld;
        logic [ADDR_W-1:0]      awAddr;
        logic                   wHeld;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   rValid;
        logic [31:0]            rData;
        logic [1:0]             rResp;
        logic [2:0]             rstPend;
        logic [2:0][CW-1:0]     rstCnt;
        logic                   rfPend;
        logic                   advPend;
    } rcc_regs_t;

    rcc_regs_t q;
    rcc_regs_t d;

    logic [4:0] rfPhase;
    logic       rfDone;
    logic       rfStart;

    // A command bit only counts when its byte lane is strobed and it carries a 1.
    function automatic logic cmdSet(input logic [31:0] data, input logic [3:0] strb,
                                    input int pos);
        cmdSet = data[pos] & strb[pos / 8];
    endfunction : cmdSet

    function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                     input logic [31:0] offset);
        addrHit = (addr == offset[ADDR_W-1:0]);
    endfunction : addrHit

    function automatic int rstBitPos(input int k);
        case (k)
            0:       rstBitPos = rcc_pkg::CORE_RST_BIT;
            1:       rstBitPos = rcc_pkg::TG_RST_BIT;
            default: rstBitPos = rcc_pkg::REG_RST_BIT;
        endcase
    endfunction : rstBitPos

    logic                awTake;
    logic                wTake;
    logic                doWrite;
    logic                ctrlWr;
    logic [ADDR_W-1:0]   wrAddr;
    logic [31:0]         wrData;
    logic [3:0]          wrStrb;
    logic                rstSet;
    logic                rstLast;
    logic [31:0]         ctrlImage;
    logic [31:0]         statImage;

    always_comb begin
        d         = q;
        awTake    = s_axi_awvalid & ~q.awHeld & ~q.bValid;
        wTake     = s_axi_wvalid & ~q.wHeld & ~q.bValid;
        wrAddr    = q.awHeld ? q.awAddr : s_axi_awaddr;
        wrData    = q.wHeld ? q.wData : s_axi_wdata;
        wrStrb    = q.wHeld ? q.wStrb : s_axi_wstrb;
        doWrite   = (q.awHeld | awTake) & (q.wHeld | wTake);
        ctrlWr    = doWrite & addrHit(wrAddr, rcc_pkg::CTRL_OFFSET);
        rstSet    = 1'b0;
        rstLast   = 1'b0;

        // Reserved bits and the uncovered lower field stay zero on reads.
        ctrlImage = rcc_pkg::CTRL_RESET;
        ctrlImage[rcc_pkg::CORE_RST_BIT]  = q.rstPend[0];
        ctrlImage[rcc_pkg::TG_RST_BIT]    = q.rstPend[1];
        ctrlImage[rcc_pkg::REG_RST_BIT]   = q.rstPend[2];
        ctrlImage[rcc_pkg::RF_ABORT_BIT]  = q.rfPend;
        ctrlImage[rcc_pkg::ADV_ABORT_BIT] = q.advPend;

        statImage = rcc_pkg::STATUS_RESET;
        statImage[rcc_pkg::STAT_PHASE_LSB +: 5] = rfPhase;
        statImage[rcc_pkg::STAT_RADIO_BIT]      = radioOff;
        statImage[rcc_pkg::STAT_ADV_BIT]        = q.advPend;

        // Write channel: address and data may arrive in either order.
        if (q.bValid && s_axi_bready) begin
            d.bValid = 1'b0;
        end
        if (doWrite) begin
            d.awHeld = 1'b0;
            d.wHeld  = 1'b0;
            d.bValid = 1'b1;
            d.bResp  = (ctrlWr | addrHit(wrAddr, rcc_pkg::STATUS_OFFSET)) ?
                       rcc_pkg::RESP_OKAY : rcc_pkg::RESP_DECERR;
        end else begin
            if (awTake) begin
                d.awHeld = 1'b1;
                d.awAddr = s_axi_awaddr;
            end
            if (wTake) begin
                d.wHeld = 1'b1;
                d.wData = s_axi_wdata;
                d.wStrb = s_axi_wstrb;
            end
        end

        // Soft resets hold their output for HOLD_COUNT cycles, then the bit drops.
        // A new request in the last cycle restarts the count rather than being lost.
        for (int k = 0; k < 3; k++) begin
            rstSet  = ctrlWr & cmdSet(wrData, wrStrb, rstBitPos(k));
            rstLast = q.rstPend[k] & (q.rstCnt[k] == CW'(1));
            if (rstSet && (!q.rstPend[k] || rstLast)) begin
                d.rstPend[k] = 1'b1;
                d.rstCnt[k]  = CW'(HOLD_COUNT);
            end else if (rstLast) begin
                d.rstPend[k] = 1'b0;
                d.rstCnt[k]  = '0;
            end else if (q.rstPend[k]) begin
                d.rstCnt[k] = q.rstCnt[k] - CW'(1);
            end
        end

        rfStart   = ctrlWr & cmdSet(wrData, wrStrb, rcc_pkg::RF_ABORT_BIT) &
                    (~q.rfPend | rfDone);
        d.rfPend  = rfStart | (q.rfPend & ~rfDone);
        d.advPend = (ctrlWr & cmdSet(wrData, wrStrb, rcc_pkg::ADV_ABORT_BIT)) |
                    (q.advPend & ~advertisingAbortDone);

        // Read channel answers one cycle after the address is taken.
        if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end
        if (s_axi_arvalid && !q.rValid) begin
            d.rValid = 1'b1;
            d.rResp  = rcc_pkg::RESP_OKAY;
            if (addrHit(s_axi_araddr, rcc_pkg::CTRL_OFFSET)) begin
                d.rData = ctrlImage;
            end else if (addrHit(s_axi_araddr, rcc_pkg::STATUS_OFFSET)) begin
                d.rData = statImage;
            end else begin
                d.rData = '0;
                d.rResp = rcc_pkg::RESP_DECERR;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    rcc_rf_abort u_rf_abort (
        .clock          (clock),
        .nrst           (nrst),
        .start          (rfStart),
        .testFormat     (testFormat),
        .byteDone       (byteDone),
        .crcDone        (crcDone),
        .accessAddrSeen (accessAddrSeen),
        .packetDone     (packetDone),
        .txStopAtByte   (txStopAtByte),
        .crcFinish      (crcFinish),
        .rxFinishPacket (rxFinishPacket),
        .radioOff       (radioOff),
        .done           (rfDone),
        .phase          (rfPhase)
    );

    assign s_axi_awready       = ~q.awHeld & ~q.bValid;
    assign s_axi_wready        = ~q.wHeld & ~q.bValid;
    assign s_axi_bvalid        = q.bValid;
    assign s_axi_bresp         = q.bResp;
    assign s_axi_arready       = ~q.rValid;
    assign s_axi_rvalid        = q.rValid;
    assign s_axi_rdata         = q.rData;
    assign s_axi_rresp         = q.rResp;
    assign coreSoftReset       = q.rstPend[0];
    assign timingGenSoftReset  = q.rstPend[1];
    assign regBlockSoftReset   = q.rstPend[2];
    assign advertisingAbortReq = q.advPend;

endmodule : rcc_command_control

// [include/rcc_pkg.sv]
package rcc_pkg;

    // Register map, byte addresses on the AXI4-Lite port.
    localparam logic [31:0] CTRL_OFFSET   = 32'h0400_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0400_0004;

    // Command bit positions inside the control register.
    localparam int CORE_RST_BIT  = 31;
    localparam int TG_RST_BIT    = 30;
    localparam int REG_RST_BIT   = 29;
    localparam int RF_ABORT_BIT  = 26;
    localparam int ADV_ABORT_BIT = 25;

    // Status register layout.
    localparam int STAT_PHASE_LSB = 0;
    localparam int STAT_RADIO_BIT = 5;
    localparam int STAT_ADV_BIT   = 6;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // Clock cycles for which each soft reset output is held high.
    localparam int RESET_HOLD_CYCLES = 4;

    // Test format codes as selected by the control structure.
    localparam logic [1:0] FMT_INF_TX = 2'h1;
    localparam logic [1:0] FMT_INF_RX = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [4:0] {
        ABT_IDLE    = 5'h01,
        ABT_TX_BYTE = 5'h02,
        ABT_TX_CRC  = 5'h04,
        ABT_RX_PKT  = 5'h08,
        ABT_DONE    = 5'h10
    } rcc_abort_state_t;

endpackage : rcc_pkg

// [design/rcc_rf_abort.sv]
`timescale 1ns/1ps
module rcc_rf_abort (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // Request from the control register and test format
    input  wire logic       start,
    input  wire logic [1:0] testFormat,
    // Packet controller progress
    input  wire logic       byteDone,
    input  wire logic       crcDone,
    input  wire logic       accessAddrSeen,
    input  wire logic       packetDone,
    // Wind-down commands, done flag and phase
    output logic            txStopAtByte,
    output logic            crcFinish,
    output logic            rxFinishPacket,
    output logic            radioOff,
    output logic            done,
    output logic [4:0]      phase
);

    typedef struct packed {
        rcc_pkg::rcc_abort_state_t state;
        logic                      radioOff;
    } rcc_abt_regs_t;

    rcc_abt_regs_t q;
    rcc_abt_regs_t d;

    always_comb begin
        d          = q;
        d.radioOff = 1'b0;
        case (q.state)
            rcc_pkg::ABT_IDLE, rcc_pkg::ABT_DONE: begin
                d.state = rcc_pkg::ABT_IDLE;
                if (start) begin
                    if (testFormat == rcc_pkg::FMT_INF_TX) begin
                        d.state = rcc_pkg::ABT_TX_BYTE;
                    end else if (testFormat == rcc_pkg::FMT_INF_RX && accessAddrSeen) begin
                        d.state = rcc_pkg::ABT_RX_PKT;
                    end else if (testFormat == rcc_pkg::FMT_INF_RX) begin
                        d.radioOff = 1'b1;
                        d.state    = rcc_pkg::ABT_DONE;
                    end else begin
                        d.state = rcc_pkg::ABT_DONE;
                    end
                end
            end
            rcc_pkg::ABT_TX_BYTE: begin
                if (byteDone) begin
                    d.state = rcc_pkg::ABT_TX_CRC;
                end
            end
            rcc_pkg::ABT_TX_CRC: begin
                if (crcDone) begin
                    d.state = rcc_pkg::ABT_DONE;
                end
            end
            rcc_pkg::ABT_RX_PKT: begin
                if (packetDone) begin
                    d.radioOff = 1'b1;
                    d.state    = rcc_pkg::ABT_DONE;
                end
            end
            default: begin
                d.state = rcc_pkg::ABT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '{state: rcc_pkg::ABT_IDLE, radioOff: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign txStopAtByte   = q.state[1];
    assign crcFinish      = q.state[2];
    assign rxFinishPacket = q.state[3];
    assign done           = q.state[4];
    assign radioOff       = q.radioOff;
    assign phase          = q.state;

endmodule : rcc_rf_abort

// [verif/rcc_command_control_props.sv]
`timescale 1ns/1ps
module rcc_command_control_props (
    // Clock, reset and write response
    input wire logic clock,
    input wire logic nrst,
    input wire logic s_axi_bvalid,
    // Command outputs and advertising abort done
    input wire logic coreSoftReset,
    input wire logic timingGenSoftReset,
    input wire logic regBlockSoftReset,
    input wire logic advertisingAbortReq,
    input wire logic advertisingAbortDone,
    // Packet controller wind-down
    input wire logic byteDone,
    input wire logic crcDone,
    input wire logic packetDone,
    input wire logic txStopAtByte,
    input wire logic crcFinish,
    input wire logic rxFinishPacket,
    input wire logic radioOff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic anyCmd = coreSoftReset | timingGenSoftReset | regBlockSoftReset
                        | advertisingAbortReq;
    // The hold figure matches the default hold count the bench instantiates.
    a_core_hold: assert property ($rose(coreSoftReset) |-> coreSoftReset[*4])
        else $error("core reset pulse too short");
    a_tg_hold: assert property ($rose(timingGenSoftReset) |-> timingGenSoftReset[*4])
        else $error("timing reset pulse too short");
    a_reg_hold: assert property ($rose(regBlockSoftReset) |-> regBlockSoftReset[*4])
        else $error("register reset pulse too short");
    a_cmd_cause: assert property ($rose(anyCmd) |-> $rose(s_axi_bvalid))
        else $error("command started without a write");
    a_adv_hold: assert property (advertisingAbortReq && !advertisingAbortDone |=> advertisingAbortReq)
        else $error("advertising abort dropped early");
    a_adv_drop: assert property ($fell(advertisingAbortReq) |-> $past(advertisingAbortDone))
        else $error("advertising abort dropped without done");
    a_tx_to_crc: assert property (txStopAtByte && byteDone |=> crcFinish && !txStopAtByte)
        else $error("no crc step after last byte");
    a_crc_wait: assert property (crcFinish && !crcDone |=> crcFinish)
        else $error("crc step left early");
    a_rx_wait: assert property (rxFinishPacket && !packetDone |=> rxFinishPacket && !radioOff)
        else $error("packet reception cut short");
    a_rx_off: assert property (rxFinishPacket && packetDone |=> radioOff ##1 !radioOff)
        else $error("radio not switched off after packet");
endmodule : rcc_command_control_props

bind rcc_command_control rcc_command_control_props i_props (
    .clock                (clock),
    .nrst                 (nrst),
    .s_axi_bvalid         (s_axi_bvalid),
    .coreSoftReset        (coreSoftReset),
    .timingGenSoftReset   (timingGenSoftReset),
    .regBlockSoftReset    (regBlockSoftReset),
    .advertisingAbortReq  (advertisingAbortReq),
    .advertisingAbortDone (advertisingAbortDone),
    .byteDone             (byteDone),
    .crcDone              (crcDone),
    .packetDone           (packetDone),
    .txStopAtByte         (txStopAtByte),
    .crcFinish            (crcFinish),
    .rxFinishPacket       (rxFinishPacket),
    .radioOff             (radioOff)
);

// [verif/test_rcc_command_control.sv]
`timescale 1ns/1ps
module test_rcc_command_control;
    logic        clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, advertisingAbortDone, byteDone, crcDone, accessAddrSeen;
    logic        packetDone, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, coreSoftReset, timingGenSoftReset, regBlockSoftReset;
    logic        advertisingAbortReq, txStopAtByte, crcFinish, rxFinishPacket, radioOff;
    logic [31:0] s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  testFormat, s_axi_bresp, s_axi_rresp, rs;
    int          miscompares = 0, n_compared = 0, nOff = 0;
    wire logic [2:0] rst3 = {coreSoftReset, timingGenSoftReset, regBlockSoftReset};
    wire logic [3:0] rfOut = {txStopAtByte, crcFinish, rxFinishPacket, radioOff};
    localparam logic [31:0] CTRL = rcc_pkg::CTRL_OFFSET;

    rcc_command_control i_dut (
        .clock                (clock),
        .nrst                 (nrst),
        .s_axi_awvalid        (s_axi_awvalid),
        .s_axi_awready        (s_axi_awready),
        .s_axi_awaddr         (s_axi_awaddr),
        .s_axi_wvalid         (s_axi_wvalid),
        .s_axi_wready         (s_axi_wready),
        .s_axi_wdata          (s_axi_wdata),
        .s_axi_wstrb          (s_axi_wstrb),
        .s_axi_bvalid         (s_axi_bvalid),
        .s_axi_bready         (s_axi_bready),
        .s_axi_bresp          (s_axi_bresp),
        .s_axi_arvalid        (s_axi_arvalid),
        .s_axi_arready        (s_axi_arready),
        .s_axi_araddr         (s_axi_araddr),
        .s_axi_rvalid         (s_axi_rvalid),
        .s_axi_rready         (s_axi_rready),
        .s_axi_rdata          (s_axi_rdata),
        .s_axi_rresp          (s_axi_rresp),
        .coreSoftReset        (coreSoftReset),
        .timingGenSoftReset   (timingGenSoftReset),
        .regBlockSoftReset    (regBlockSoftReset),
        .advertisingAbortReq  (advertisingAbortReq),
        .advertisingAbortDone (advertisingAbortDone),
        .testFormat           (testFormat),
        .byteDone             (byteDone),
        .crcDone              (crcDone),
        .accessAddrSeen       (accessAddrSeen),
        .packetDone           (packetDone),
        .txStopAtByte         (txStopAtByte),
        .crcFinish            (crcFinish),
        .rxFinishPacket       (rxFinishPacket),
        .radioOff             (radioOff)
    );

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (radioOff === 1'h1) nOff++;

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        rs = s_axi_bresp;
        if (i == 50) begin
            miscompares++;
            end_sim();
        end
    endtask : wr

    task automatic rd_reg(input logic [31:0] a);
        int i;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        if (i == 50) begin
            miscompares++;
            end_sim();
        end
    endtask : rd_reg

    // Raises one progress input for a single cycle: 0 adv done, 1 byte, 2 crc, 3 packet.
    task automatic pulse(input int sel);
        @(posedge clock);
        advertisingAbortDone <= (sel == 0);
        byteDone             <= (sel == 1);
        crcDone              <= (sel == 2);
        packetDone           <= (sel == 3);
        @(posedge clock);
        {advertisingAbortDone, byteDone, crcDone, packetDone} <= 4'h0;
    endtask : pulse

    task automatic t_regs;
        rd_reg(CTRL);
        check(rd, rcc_pkg::CTRL_RESET);
        wr(CTRL, 32'h1800_0000, 4'hF);
        check(32'(rs), 32'(rcc_pkg::RESP_OKAY));
        rd_reg(CTRL);
        check(rd, 32'h0);
        rd_reg(32'h0000_0100);
        check(32'(rs), 32'(rcc_pkg::RESP_DECERR));
        $display("test regs done");
    endtask : t_regs

    task automatic t_no_action;
        wr(CTRL, 32'h0, 4'hF);
        // Command byte left out of the strobes, so nothing may start.
        wr(CTRL, 32'hE600_0000, 4'h7);
        repeat (6) @(posedge clock);
        check(32'({rst3, advertisingAbortReq, rfOut}), 32'h0);
        check(32'(nOff), 32'h0);
        $display("test no action done");
    endtask : t_no_action

    task automatic t_soft;
        int n;
        for (int k = 0; k < 3; k++) begin
            wr(CTRL, 32'h8000_0000 >> k, 4'hF);
            n = 0;
            for (int i = 0; i < 12; i++) begin
                if (rst3 === (3'h4 >> k)) n++;
                else if (rst3 !== 3'h0) n += 100;
                @(posedge clock);
            end
            check(n, rcc_pkg::RESET_HOLD_CYCLES);
            rd_reg(CTRL);
            check(rd, 32'h0);
        end
        $display("test soft resets done");
    endtask : t_soft

    task automatic t_adv;
        wr(CTRL, 32'h0200_0000, 4'hF);
        check(32'(advertisingAbortReq), 32'h1);
        rd_reg(CTRL);
        check(rd, 32'h0200_0000);
        rd_reg(rcc_pkg::STATUS_OFFSET);
        check(32'(rd[rcc_pkg::STAT_ADV_BIT]), 32'h1);
        pulse(0);
        @(posedge clock);
        check(32'(advertisingAbortReq), 32'h0);
        rd_reg(CTRL);
        check(rd, 32'h0);
        $display("test advertising abort done");
    endtask : t_adv

    task automatic t_rf_tx;
        testFormat <= rcc_pkg::FMT_INF_TX;
        wr(CTRL, 32'h0400_0000, 4'hF);
        repeat (4) @(posedge clock);
        check(32'(rfOut), 32'h8);
        rd_reg(rcc_pkg::STATUS_OFFSET);
        check(rd, 32'h0000_0002);
        pulse(1);
        @(posedge clock);
        check(32'(rfOut), 32'h4);
        pulse(2);
        repeat (4) @(posedge clock);
        check(32'(rfOut), 32'h0);
        rd_reg(CTRL);
        check(rd, 32'h0);
        $display("test rf tx abort done");
    endtask : t_rf_tx

    task automatic t_rf_rx;
        int o0;
        o0 = nOff;
        testFormat <= rcc_pkg::FMT_INF_RX;
        accessAddrSeen <= 1'h1;
        wr(CTRL, 32'h0400_0000, 4'hF);
        accessAddrSeen <= 1'h0;
        repeat (4) @(posedge clock);
        check(32'(rfOut), 32'h2);
        check(nOff, o0);
        pulse(3);
        repeat (3) @(posedge clock);
        check(nOff, o0 + 1);
        wr(CTRL, 32'h0400_0000, 4'hF);
        repeat (4) @(posedge clock);
        check(nOff, o0 + 2);
        rd_reg(CTRL);
        check(rd, 32'h0);
        testFormat <= 2'h0;
        wr(CTRL, 32'h0400_0000, 4'hF);
        repeat (4) @(posedge clock);
        rd_reg(CTRL);
        check({rd[31:4], rfOut}, 32'h0);
        $display("test rf rx abort done");
    endtask : t_rf_rx

    initial begin
        nrst = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {advertisingAbortDone, byteDone, crcDone, accessAddrSeen, packetDone} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 96'h0;
        s_axi_wstrb = 4'h0;
        testFormat = 2'h0;
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        t_regs();
        t_no_action();
        t_soft();
        t_adv();
        t_rf_tx();
        t_rf_rx();
        end_sim();
    end
endmodule : test_rcc_command_control
